// ### src/edap_port.sv
// Top of the external DRAM access port: hold handshake, access sequencing and memory-controller requests.
// Assumes the memory controller answers a line command with a one-cycle ack while the request stays high.
//
// Function
// [RULE1] Select low, direction low in hold: write
// [RULE2] Write only the strobed byte lanes
// [RULE3] Drive access done low after write
// [RULE4] Gather writes in 128-bit line buffer
// [RULE5] Same-line accesses finish in one period; a read of a dirty or unfilled line goes through flush/fill first
// [RULE6] Line-change write takes three to seven periods
// [RULE7] Started access always runs to completion
// [RULE8] Master holds controls stable during waits
// [RULE9] Master raises select within one period
// [RULE10] Master drops hold after select rises
// [RULE11] Master never flips direction mid-select
// [RULE12] Master idles one period between read/write
// [RULE13] Port keeps working during CPU sleep
// [RULE14] Standby waits for current access, flush
// [RULE15] Hold request low: enter hold, grant
// [RULE16] Reads drive full halfword regardless strobes
// [RULE17] Line-change read three to seven periods
// [RULE18] Upper strobe high byte, lower low
// [RULE19] Outside hold: ignore select, float outputs
`timescale 1ns/1ps
`default_nettype none
module edap_port #(
	parameter int ADDR_W = edap_pkg::ADDR_W
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          srst,
	// Hold handshake
	input  wire logic                          hold_request_n,
	output logic                               hold_grant_n,
	// External access pins
	input  wire logic                          cs_n,
	input  wire logic                          rd_wr_n,
	input  wire logic                          upper_byte_strobe_n,
	input  wire logic                          lower_byte_strobe_n,
	input  wire logic [ADDR_W-1:0]             addr,
	input  wire logic [edap_pkg::HW_W-1:0]     data_in,
	output logic      [edap_pkg::HW_W-1:0]     data_out,
	output logic                               data_oe,
	output logic                               access_done_n,
	output logic                               access_done_oe,
	// Memory controller
	output logic                               dram_req,
	output edap_pkg::edap_dram_cmd_type        dram_cmd,
	input  wire logic                          dram_ack,
	input  wire logic [edap_pkg::LINE_BITS-1:0] dram_rdata,
	// Power management
	input  wire logic                          standby_req,
	output logic                               standby_ready
);
	typedef enum logic [2:0] {ST_IDLE, ST_FLUSH, ST_FILL, ST_SETTLE, ST_DONE} edap_state_type;

	edap_state_type                  state_r, state_nxt;
	edap_pkg::edap_req_type          req_r, req_nxt;
	logic [edap_pkg::CNT_W-1:0]      cnt_r, cnt_nxt;
	logic                            hold_r, hold_nxt;
	logic                            stby_flush_r, stby_flush_nxt;
	logic [edap_pkg::HW_W-1:0]       dout_nxt;
	logic                            dram_req_nxt;
	edap_pkg::edap_dram_cmd_type     dram_cmd_nxt;
	logic                            ready_nxt;

	edap_pkg::edap_req_type          pin_req;
	logic                            take;
	logic                            fill, retag, flushed, wr;
	logic [edap_pkg::IDX_W-1:0]      wr_idx;
	logic [edap_pkg::HW_W-1:0]       wr_data;
	logic [1:0]                      wr_be;
	logic [edap_pkg::LINE_BITS-1:0]  line_data;
	logic [edap_pkg::BYTES_PER_LINE-1:0] line_mask;
	logic [edap_pkg::TAG_W-1:0]      line_tag;
	logic                            line_valid, line_dirty;
	logic                            pin_hit_wr, pin_hit_rd;

	// ************************************************************
	// Line buffer
	// ************************************************************
	edap_line_buf u_buf (
		.mclk       (mclk),
		.srst       (srst),
		.fill       (fill),
		.retag      (retag),
		.flushed    (flushed),
		.new_tag    (req_r.addr[ADDR_W-1:edap_pkg::IDX_W]),
		.fill_data  (dram_rdata),
		.wr         (wr),
		.wr_idx     (wr_idx),
		.wr_data    (wr_data),
		.wr_be      (wr_be),
		.line_data  (line_data),
		.line_mask  (line_mask),
		.line_tag   (line_tag),
		.line_valid (line_valid),
		.line_dirty (line_dirty)
	);

	// ************************************************************
	// Request decode
	// ************************************************************
	// Pins packed into one request; select counts only in hold and when not entering standby
	always_comb begin
		pin_req.rd   = rd_wr_n;
		pin_req.ub_n = upper_byte_strobe_n;
		pin_req.lb_n = lower_byte_strobe_n;
		pin_req.addr = addr;
		take         = hold_r && !cs_n && (state_r == ST_IDLE) && !standby_req; // RULE1 RULE19 RULE14
		pin_hit_wr   = (line_tag == addr[ADDR_W-1:edap_pkg::IDX_W]); // Writes gather into the same-tag line, filled or not
		pin_hit_rd   = pin_hit_wr && line_valid && !line_dirty; // Reads need a clean filled line
	end

	// ************************************************************
	// Access sequencer
	// ************************************************************
	// Hits finish next edge; line changes wait for the controller and the least latency
	always_comb begin
		state_nxt      = state_r;
		req_nxt        = req_r;
		cnt_nxt        = cnt_r + 1'b1;
		stby_flush_nxt = stby_flush_r;
		fill           = 1'b0;
		retag          = 1'b0;
		flushed        = 1'b0;
		wr             = 1'b0;
		wr_idx         = req_r.addr[edap_pkg::IDX_W-1:0];
		wr_data        = data_in;
		wr_be          = {!req_r.ub_n, !req_r.lb_n};
		case (state_r)
			ST_IDLE: begin
				cnt_nxt = edap_pkg::CNT_START;
				if (take) begin
					req_nxt = pin_req;
					if (pin_req.rd ? pin_hit_rd : pin_hit_wr) begin
						state_nxt = ST_DONE; // RULE5 RULE17
						wr        = !pin_req.rd; // RULE4
						wr_idx    = addr[edap_pkg::IDX_W-1:0];
						wr_be     = {!upper_byte_strobe_n, !lower_byte_strobe_n};
					end else if (line_dirty) begin
						state_nxt = ST_FLUSH;
					end else if (pin_req.rd) begin
						state_nxt = ST_FILL;
					end else begin
						state_nxt = ST_SETTLE; // RULE6
					end
				end else if (standby_req && line_dirty) begin
					state_nxt      = ST_FLUSH; // RULE14
					stby_flush_nxt = 1'b1;
				end
			end
			ST_FLUSH: begin
				if (dram_ack) begin
					flushed = 1'b1;
					if (stby_flush_r) begin
						state_nxt      = ST_IDLE;
						stby_flush_nxt = 1'b0;
					end else begin
						state_nxt = req_r.rd ? ST_FILL : ST_SETTLE;
					end
				end
			end
			ST_FILL: begin
				if (dram_ack) begin
					fill      = 1'b1;
					state_nxt = ST_SETTLE; // RULE17
				end
			end
			ST_SETTLE: begin
				// Write misses open the new line first, after a flush too, then take the data
				retag = !req_r.rd && (line_tag != req_r.addr[ADDR_W-1:edap_pkg::IDX_W]);
				if ((cnt_r >= edap_pkg::CNT_SETTLE) && !retag) begin
					state_nxt = ST_DONE; // RULE6 RULE7
					wr        = !req_r.rd; // RULE4
				end
			end
			ST_DONE: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ************************************************************
	// Pin outputs and hold
	// ************************************************************
	// Hold is entered at once but left only with the sequencer idle
	always_comb begin
		hold_nxt = hold_r;
		if (!hold_request_n) begin
			hold_nxt = 1'b1; // RULE15
		end else if ((state_r == ST_IDLE) && !take) begin
			hold_nxt = 1'b0; // RULE7
		end
		dout_nxt = data_out;
		if ((state_nxt == ST_DONE) && (state_r != ST_DONE)) begin
			dout_nxt = (state_r == ST_IDLE) ? line_data[addr[edap_pkg::IDX_W-1:0]*edap_pkg::HW_W +: edap_pkg::HW_W]
			                                : line_data[wr_idx*edap_pkg::HW_W +: edap_pkg::HW_W]; // RULE16
		end
		ready_nxt = standby_req && (state_r == ST_IDLE) && !take && !line_dirty; // RULE14
	end

	// ************************************************************
	// Memory controller command
	// ************************************************************
	// Request stays high while a flush or fill is pending
	always_comb begin
		dram_req_nxt      = (state_nxt == ST_FLUSH) || (state_nxt == ST_FILL);
		dram_cmd_nxt      = dram_cmd;
		if (state_nxt == ST_FLUSH) begin
			dram_cmd_nxt.we   = 1'b1;
			dram_cmd_nxt.tag  = line_tag;
			dram_cmd_nxt.data = line_data;
			dram_cmd_nxt.mask = line_mask; // RULE2
		end else if (state_nxt == ST_FILL) begin
			dram_cmd_nxt.we   = 1'b0;
			dram_cmd_nxt.tag  = req_r.rd && (state_r != ST_IDLE) ? req_r.addr[ADDR_W-1:edap_pkg::IDX_W]
			                                                     : addr[ADDR_W-1:edap_pkg::IDX_W];
			dram_cmd_nxt.mask = '0;
		end
	end

	// Registers; this logic runs on the port clock, untouched by CPU sleep
	always_ff @(posedge mclk) begin // RULE13
		if (srst) begin
			state_r        <= ST_IDLE;
			req_r          <= '0;
			cnt_r          <= '0;
			hold_r         <= 1'b0;
			stby_flush_r   <= 1'b0;
			hold_grant_n   <= 1'b1;
			data_out       <= '0;
			data_oe        <= 1'b0;
			access_done_n  <= 1'b1;
			access_done_oe <= 1'b0;
			dram_req       <= 1'b0;
			dram_cmd       <= '0;
			standby_ready  <= 1'b0;
		end else begin
			state_r        <= state_nxt;
			req_r          <= req_nxt;
			cnt_r          <= cnt_nxt;
			hold_r         <= hold_nxt;
			stby_flush_r   <= stby_flush_nxt;
			hold_grant_n   <= !hold_nxt; // RULE15
			data_out       <= dout_nxt;
			data_oe        <= hold_nxt && !cs_n && rd_wr_n; // RULE16 RULE19
			access_done_n  <= (state_nxt != ST_DONE); // RULE3
			access_done_oe <= hold_nxt && !cs_n; // RULE19
			dram_req       <= dram_req_nxt;
			dram_cmd       <= dram_cmd_nxt;
			standby_ready  <= ready_nxt;
		end
	end

endmodule // edap_port
`default_nettype wire

// ### src/edap_pkg.sv
// Shared constants and carrier types for the external DRAM access port.
// Assumes the port clock is the input clock itself, so one mclk period is one input-clock period.
package edap_pkg;

	// ************************************************************
	// Geometry
	// ************************************************************
	localparam int ADDR_W         = 23;                // Halfword address lines
	localparam int HW_W           = 16;                // Data lines per access
	localparam int LINE_BITS      = 128;               // Buffered line width
	localparam int HW_PER_LINE    = LINE_BITS / HW_W;  // Halfwords per line
	localparam int IDX_W          = $clog2(HW_PER_LINE);
	localparam int BYTES_PER_LINE = LINE_BITS / 8;
	localparam int TAG_W          = ADDR_W - IDX_W;
	localparam int BE_UPPER       = 1;                 // Byte enable bit of the upper lane
	localparam int BE_LOWER       = 0;                 // Byte enable bit of the lower lane

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ          = 25_000_000;
	localparam int INPUT_CLOCK_HZ        = 25_000_000;
	localparam int LINE_LAT_MIN    = 3;                // Input-clock periods, line change, least
	localparam int LINE_LAT_MAX    = 7;                // Input-clock periods, line change, most
	localparam int LAT_MIN_CYC     = (LINE_LAT_MIN * CLK_HZ + INPUT_CLOCK_HZ - 1) / INPUT_CLOCK_HZ;
	localparam int LAT_MAX_CYC     = (LINE_LAT_MAX * CLK_HZ) / INPUT_CLOCK_HZ;
	localparam int CNT_W           = $clog2(LAT_MAX_CYC + 1) + 1;
	localparam logic [CNT_W-1:0] CNT_START  = CNT_W'(1);
	localparam logic [CNT_W-1:0] CNT_SETTLE = CNT_W'(LAT_MIN_CYC - 1);

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic              rd;     // High for read
		logic              ub_n;   // Upper byte strobe, active low
		logic              lb_n;   // Lower byte strobe, active low
		logic [ADDR_W-1:0] addr;   // Halfword address
	} edap_req_type;

	typedef struct packed {
		logic                      we;    // High for line write
		logic [TAG_W-1:0]          tag;   // Line address
		logic [LINE_BITS-1:0]      data;  // Line data
		logic [BYTES_PER_LINE-1:0] mask;  // Bytes to write
	} edap_dram_cmd_type;

endpackage

// ### src/edap_line_buf.sv
// 128-bit line buffer of the bus interface unit with per-byte dirty marks.
// Assumes the owner never asks for fill, retag and write in the same cycle.
// line_valid means the line was filled from memory; a retagged line holds only strobed bytes.
`timescale 1ns/1ps
`default_nettype none
module edap_line_buf #(
	parameter int LINE_BITS = edap_pkg::LINE_BITS,
	parameter int HW_W      = edap_pkg::HW_W,
	parameter int TAG_W     = edap_pkg::TAG_W,
	parameter int IDX_W     = edap_pkg::IDX_W
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   srst,
	// Control
	input  wire logic                   fill,
	input  wire logic                   retag,
	input  wire logic                   flushed,
	input  wire logic [TAG_W-1:0]       new_tag,
	input  wire logic [LINE_BITS-1:0]   fill_data,
	input  wire logic                   wr,
	input  wire logic [IDX_W-1:0]       wr_idx,
	input  wire logic [HW_W-1:0]        wr_data,
	input  wire logic [1:0]             wr_be,
	// State
	output logic [LINE_BITS-1:0]        line_data,
	output logic [LINE_BITS/8-1:0]      line_mask,
	output logic [TAG_W-1:0]            line_tag,
	output logic                        line_valid,
	output logic                        line_dirty
);
	localparam int NHW = LINE_BITS / HW_W;

	logic [TAG_W-1:0] tag_r;
	logic [TAG_W-1:0] tag_nxt;
	logic             valid_r;
	logic             valid_nxt;

	// ************************************************************
	// Tag and valid
	// ************************************************************
	// New line address on fill or retag
	always_comb begin
		tag_nxt   = tag_r;
		valid_nxt = valid_r;
		if (fill) begin
			tag_nxt   = new_tag;
			valid_nxt = 1'b1; // Line now mirrors memory
		end else if (retag) begin
			tag_nxt   = new_tag;
			valid_nxt = 1'b0; // Unstrobed bytes are stale, not readable
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			tag_r   <= '0;
			valid_r <= 1'b0;
		end else begin
			tag_r   <= tag_nxt;
			valid_r <= valid_nxt;
		end
	end

	// ************************************************************
	// Halfword lanes
	// ************************************************************
	for (genvar k = 0; k < NHW; k++) begin : g_hw
		logic [HW_W-1:0] d_r;
		logic [HW_W-1:0] d_nxt;
		logic [1:0]      m_r;
		logic [1:0]      m_nxt;

		// Fill loads every byte clean; writes change only strobed bytes and mark them dirty
		always_comb begin
			d_nxt = d_r;
			m_nxt = m_r;
			if (fill) begin
				d_nxt = fill_data[k*HW_W +: HW_W];
				m_nxt = 2'b00;
			end else if (retag || flushed) begin
				m_nxt = 2'b00;
			end
			if (wr && (wr_idx == IDX_W'(k))) begin
				if (wr_be[edap_pkg::BE_UPPER]) begin
					d_nxt[HW_W-1:HW_W/2]          = wr_data[HW_W-1:HW_W/2]; // RULE2 RULE18
					m_nxt[edap_pkg::BE_UPPER]     = 1'b1;
				end
				if (wr_be[edap_pkg::BE_LOWER]) begin
					d_nxt[HW_W/2-1:0]             = wr_data[HW_W/2-1:0]; // RULE2 RULE18
					m_nxt[edap_pkg::BE_LOWER]     = 1'b1;
				end
			end
		end

		always_ff @(posedge mclk) begin
			if (srst) begin
				d_r <= '0;
				m_r <= 2'b00;
			end else begin
				d_r <= d_nxt;
				m_r <= m_nxt;
			end
		end

		assign line_data[k*HW_W +: HW_W] = d_r;
		assign line_mask[2*k +: 2]       = m_r;
	end

	// Status outputs
	assign line_tag   = tag_r;
	assign line_valid = valid_r;
	assign line_dirty = |line_mask;

endmodule // edap_line_buf
`default_nettype wire

// ### test/edap_port_asserts.sv
// Concurrent checks on the pins of the external DRAM access port.
// Assumes it is bound to edap_port and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module edap_port_asserts #(
	parameter int ADDR_W = edap_pkg::ADDR_W
) (
	// Clock and reset
	input wire logic                        mclk,
	input wire logic                        srst,
	// Host pins
	input wire logic                        hold_request_n,
	input wire logic                        hold_grant_n,
	input wire logic                        cs_n,
	input wire logic                        rd_wr_n,
	input wire logic [ADDR_W-1:0]           addr,
	input wire logic                        data_oe,
	input wire logic                        access_done_n,
	input wire logic                        access_done_oe,
	// Memory controller and power
	input wire logic                        dram_req,
	input wire edap_pkg::edap_dram_cmd_type dram_cmd,
	input wire logic                        dram_ack,
	input wire logic                        standby_req,
	input wire logic                        standby_ready
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic [ADDR_W-4:0] line_q;

	// Line of the address one cycle back
	always_ff @(posedge mclk) begin
		line_q <= addr[ADDR_W-1:3];
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// ****************************************
	// Checks
	// ****************************************
	grant_follow_a: assert property (!hold_request_n |=> !hold_grant_n)
		else $error("hold grant missing after request");
	done_pulse_a: assert property (!access_done_n |=> access_done_n)
		else $error("done held low past one cycle");
	done_driven_a: assert property (!access_done_n |-> access_done_oe)
		else $error("done pulse while pin floats");
	float_out_a: assert property (hold_grant_n && $past(hold_grant_n) |-> !access_done_oe && !data_oe && access_done_n)
		else $error("port active outside hold");
	read_drive_a: assert property (!hold_grant_n && !cs_n && rd_wr_n |=> data_oe)
		else $error("read data not driven");
	sel_done_oe_a: assert property (!hold_grant_n && !cs_n |=> access_done_oe)
		else $error("done pin not driven on select");
	same_line_a: assert property ((!access_done_n && !cs_n && !hold_grant_n && !standby_req) ##1
		(!cs_n && !standby_req && $stable(rd_wr_n) && addr[ADDR_W-1:3] == line_q) |=> !access_done_n)
		else $error("same line access not done in one period");
	cmd_hold_a: assert property (dram_req && !dram_ack |=> dram_req && $stable(dram_cmd))
		else $error("line command dropped before ack");
	miss_min_a: assert property ($rose(dram_req) |-> access_done_n [*2])
		else $error("line change finished too early");
	ready_idle_a: assert property (standby_ready |-> !dram_req)
		else $error("standby ready with command pending");
endmodule // edap_port_asserts
`default_nettype wire

// ### test/edap_dram_model.sv
// Stand-in for the memory controller and internal DRAM behind the port.
// Assumes one line command at a time, held until its ack pulse.
`timescale 1ns/1ps
`default_nettype none
module edap_dram_model (
	// Clock and reset
	input wire logic                        mclk,
	input wire logic                        srst,
	// Line command
	input wire logic                        dram_req,
	input wire edap_pkg::edap_dram_cmd_type dram_cmd,
	output logic                            dram_ack,
	output logic [edap_pkg::LINE_BITS-1:0]  dram_rdata,
	// Answer delay and write count
	input wire logic [3:0]                  lat,
	output int                              writes
);
	logic [edap_pkg::LINE_BITS-1:0] mem [int];
	logic [edap_pkg::LINE_BITS-1:0] line;
	logic [3:0]                     cnt;

	initial dram_rdata = '0;

	// Wait lat cycles, answer once; read data turns over except when answering a read
	always @(posedge mclk) begin
		dram_ack <= 1'b0;
		dram_rdata <= ~dram_rdata;
		if (srst) begin
			writes <= 0;
		end
		if (srst || !dram_req || dram_ack) begin
			cnt <= 4'h0;
		end else if (cnt != lat) begin
			cnt <= cnt + 4'h1;
		end else begin
			line = mem.exists(int'(dram_cmd.tag)) ? mem[int'(dram_cmd.tag)] : {8{dram_cmd.tag[15:0]}};
			dram_ack <= 1'b1;
			if (dram_cmd.we) begin
				// Only marked bytes of the line change
				for (int b = 0; b < 16; b++) begin
					if (dram_cmd.mask[b]) line[8*b +: 8] = dram_cmd.data[8*b +: 8];
				end
				mem[int'(dram_cmd.tag)] = line;
				writes <= writes + 1;
			end else begin
				dram_rdata <= line;
			end
		end
	end
endmodule // edap_dram_model
`default_nettype wire

// ### test/edap_port_tb_top.sv
// Self-checking bench for the external DRAM access port; the bench plays the bus master.
// Assumes the package, the port and the DRAM stand-in are compiled first.
`timescale 1ns/1ps
`default_nettype none
module edap_port_tb_top;
	logic mclk, srst, hold_request_n, cs_n, rd_wr_n, ub_n, lb_n, standby_req;
	logic hold_grant_n, data_oe, access_done_n, access_done_oe, dram_req, dram_ack, standby_ready;
	logic [22:0] addr, base;
	logic [15:0] data_in, data_out, seed;
	logic [127:0] dram_rdata;
	logic [19:0] prev_tag;
	logic [3:0] lat;
	logic prev_rd, prev_ok;
	edap_pkg::edap_dram_cmd_type dram_cmd;
	logic [15:0] exp_mem [int];
	int errors, checks_done, writes, w0;

	// ****************************************
	// Design and far side
	// ****************************************
	edap_port dut (.mclk(mclk), .srst(srst), .hold_request_n(hold_request_n), .hold_grant_n(hold_grant_n),
		.cs_n(cs_n), .rd_wr_n(rd_wr_n), .upper_byte_strobe_n(ub_n), .lower_byte_strobe_n(lb_n),
		.addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.access_done_n(access_done_n), .access_done_oe(access_done_oe), .dram_req(dram_req),
		.dram_cmd(dram_cmd), .dram_ack(dram_ack), .dram_rdata(dram_rdata),
		.standby_req(standby_req), .standby_ready(standby_ready));
	edap_dram_model u_dram (.mclk(mclk), .srst(srst), .dram_req(dram_req), .dram_cmd(dram_cmd),
		.dram_ack(dram_ack), .dram_rdata(dram_rdata), .lat(lat), .writes(writes));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] exp_of(input logic [22:0] a);
		return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : a[18:3];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks_done++;
		if (seen !== want) begin
			errors++;
			$display("mismatch at %0t: %s seen %h want %h", $time, what, seen, want);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// One access; controls stay put until done is seen, then select stays or rises
	task automatic acc(input logic rd, input logic [22:0] a, input logic keep);
		int n;
		logic [15:0] d, e;
		logic [1:0] be;
		n = 0;
		seed = lfsr(seed);
		d = seed;
		be = rd ? 2'h0 : ((seed[9:8] == 2'h3) ? 2'h0 : seed[9:8]); // Every write dirties at least one byte
		cs_n <= 1'b0;
		rd_wr_n <= rd;
		addr <= a;
		data_in <= d;
		ub_n <= be[1];
		lb_n <= be[0];
		do begin
			@(posedge mclk);
			n++;
		end while (access_done_n !== 1'b0 && n < 40);
		check(n < 40, 1, "done timeout");
		if (prev_ok && a[22:3] == prev_tag && rd == prev_rd) begin
			check(32'(n - 1), 1, "same line time");
		end else if (a[22:3] != prev_tag && lat == 4'h0) begin
			check(n >= 4 && n <= 8, 1, "line change time");
		end
		if (rd) begin
			check(data_out, exp_of(a), "read data");
		end else begin
			e = exp_of(a);
			if (!be[1]) e[15:8] = d[15:8];
			if (!be[0]) e[7:0] = d[7:0];
			exp_mem[int'(a)] = e;
		end
		check(access_done_oe, 1, "done pin driven");
		prev_tag = a[22:3];
		prev_rd = rd;
		prev_ok = 1'b1;
		if (!keep) begin
			cs_n <= 1'b1;
			data_in <= ~d;
		end
	endtask

	// Select low outside hold must leave the pins floating
	task automatic float_chk();
		cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
		check(access_done_oe, 0, "done pin floats");
		check(data_oe, 0, "data floats");
		check(access_done_n, 1, "no done outside hold");
		cs_n <= 1'b1;
		@(posedge mclk);
	endtask

	// ****************************************
	// Clock, watchdog and sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	initial begin
		#2_000_000;
		errors++;
		print_verdict();
	end

	initial begin
		srst = 1'b1; hold_request_n = 1'b1; cs_n = 1'b1; rd_wr_n = 1'b1; ub_n = 1'b1; lb_n = 1'b1;
		standby_req = 1'b0; addr = '0; data_in = '0; lat = 4'h0; seed = 16'h000a;
		errors = 0; checks_done = 0; prev_ok = 1'b0; prev_tag = '0; prev_rd = 1'b0;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		check(hold_grant_n, 1, "grant after reset");
		check(dram_req, 0, "no command after reset");
		float_chk();
		hold_request_n <= 1'b0;
		repeat (2) @(posedge mclk);
		check(hold_grant_n, 0, "grant in hold");
		$display("test hold entry done");
		// Six groups, each six writes then six reads, memory fast and slow by turns
		for (int g = 0; g < 6; g++) begin
			lat <= g[0] ? 4'h3 : 4'h0;
			seed = lfsr(seed);
			base = {4'h0, seed, 3'h0};
			for (int i = 0; i < 6; i++) acc(1'b0, base + 23'(i * 3), i < 5);
			@(posedge mclk);
			for (int i = 0; i < 6; i++) acc(1'b1, base + 23'(i * 3), i < 5);
			@(posedge mclk);
			$display("test group %0d done", g);
		end
		// Dirty line, then standby must write it back before ready
		acc(1'b0, base + 23'h00_0001, 1'b0);
		w0 = writes;
		standby_req <= 1'b1;
		for (int k = 0; k < 40 && standby_ready !== 1'b1; k++) @(posedge mclk);
		check(standby_ready, 1, "standby ready");
		check(writes > w0, 1, "line written back");
		standby_req <= 1'b0;
		prev_ok = 1'b0;
		repeat (2) @(posedge mclk);
		acc(1'b1, base + 23'h00_0001, 1'b0);
		$display("test standby done");
		hold_request_n <= 1'b1;
		repeat (3) @(posedge mclk);
		check(hold_grant_n, 1, "grant released");
		float_chk();
		$display("test hold exit done");
		print_verdict();
	end
endmodule // edap_port_tb_top

bind edap_port edap_port_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk(mclk), .srst(srst),
	.hold_request_n(hold_request_n), .hold_grant_n(hold_grant_n), .cs_n(cs_n), .rd_wr_n(rd_wr_n),
	.addr(addr), .data_oe(data_oe), .access_done_n(access_done_n), .access_done_oe(access_done_oe),
	.dram_req(dram_req), .dram_cmd(dram_cmd), .dram_ack(dram_ack), .standby_req(standby_req),
	.standby_ready(standby_ready));
`default_nettype wire
